// ===== src/fwtr_pkg.sv
// Constants, offsets and state codes for the four-wire touch readout.
// Assumes a single 25 MHz system clock and an AXI4-Lite register master.
package fwtr_pkg;
    // =====================================================
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int DEBOUNCE_US = 100;
    localparam int SETTLE_US = 10;
    localparam logic [15:0] RST_DEBOUNCE = 16'(DEBOUNCE_US * CLK_MHZ);
    localparam logic [15:0] RST_SETTLE = 16'(SETTLE_US * CLK_MHZ);
    localparam logic [1:0] RST_SAMP_LOG = 2'h2;
    // =====================================================
    // Sample format
    localparam int ADC_W = 10;
    localparam int ACC_W = 13;
    // =====================================================
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DEBOUNCE = 8'h04;
    localparam logic [7:0] OFF_SETTLE = 8'h08;
    localparam logic [7:0] OFF_SAMPLES = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    localparam logic [7:0] OFF_XPOS = 8'h18;
    localparam logic [7:0] OFF_YPOS = 8'h1C;
    localparam logic [7:0] OFF_LIVE = 8'h20;
    // =====================================================
    // Status and mask bit positions
    localparam int ST_TOUCH = 0;
    localparam int ST_DONE = 1;
    localparam int ST_DISCARD = 2;
    localparam int ST_W = 3;
    // =====================================================
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // =====================================================
    // Sequencer states
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_DETECT = 8'h02,
        S_DEBOUNCE = 8'h04,
        S_XSETTLE = 8'h08,
        S_XSAMPLE = 8'h10,
        S_YSETTLE = 8'h20,
        S_YSAMPLE = 8'h40,
        S_CHECK = 8'h80
    } fwtr_state_t;
endpackage

// ===== src/fwtr_readout.sv
// Four-wire resistive touch panel sequencer with AXI4-Lite registers.
// Assumes an external 10-bit ADC on clk_sys and pad cells that honour
// the enable and pullup controls below; only xHighIn comes from a pin.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.

// Summary of operation
// - Detect mode: x-high input with pullup, y-low driven zero, others open.
// - Low x-high level during detect counts as touch and raises touch interrupt.
// - X read: x-high driven one, x-low zero, y-low open, sample y-high.
// - Y read: y-high driven one, y-low zero, x-low open, sample x-high.
// - Low-side lines are only ever floated or pulled to zero.
// - Detect, settle and read both axes automatically without software steps.
// - Completion interrupt after the programmed number of conversions.
// - Samples are raw 10-bit values covering 1024 counts.
// - Debounce, reconfirm touch, repeat reads while held, clear touch on release.
// - Wait programmed settle after each axis setup, then take programmed samples.
module fwtr_readout
    import fwtr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic xHighIn,
    output logic xHighOut,
    output logic xHighOe,
    output logic xHighPullEn,
    output logic yHighOut,
    output logic yHighOe,
    output logic xLowOut,
    output logic xLowOe,
    output logic yLowOut,
    output logic yLowOe,
    output logic adcStart,
    output logic adcSelXHigh,
    input wire logic adcDone,
    input wire logic [ADC_W-1:0] adcData,
    output logic irq
);
    // =====================================================
    // Registers and state
    fwtr_state_t state, next_state;
    logic ctrlEnable;
    logic [15:0] debounceReg, settleReg, delayCnt, next_delay;
    logic [1:0] sampLog;
    logic [ST_W-1:0] status, maskReg;
    logic [ADC_W-1:0] xPos, yPos;
    logic [ACC_W-1:0] xAcc, yAcc;
    logic [3:0] sampCnt;
    logic adcBusy;
    logic syncA, syncB;
    logic awHeld, wHeld;
    logic [7:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;

    // =====================================================
    // Pin synchroniser; touch reads as a low sense level
    always_ff @(posedge clk_sys) begin
        syncA <= xHighIn;
        syncB <= syncA;
    end
    wire touchNow = !syncB;

    // =====================================================
    // Line drive per configuration
    wire cfgDetect = (state == S_DETECT) || (state == S_DEBOUNCE) || (state == S_CHECK);
    wire cfgX = (state == S_XSETTLE) || (state == S_XSAMPLE);
    wire cfgY = (state == S_YSETTLE) || (state == S_YSAMPLE);
    assign xHighPullEn = cfgDetect;
    assign yLowOe = cfgDetect || cfgY;
    assign xHighOe = cfgX;
    assign xHighOut = cfgX;
    assign xLowOe = cfgX;
    assign yHighOe = cfgY;
    assign yHighOut = cfgY;
    // Low-side pads never source current, so a fixed zero is all they need
    assign xLowOut = 1'b0;
    assign yLowOut = 1'b0;
    assign adcSelXHigh = cfgY;

    // =====================================================
    // Conversion control
    wire sampling = (state == S_XSAMPLE) || (state == S_YSAMPLE);
    wire [3:0] sampGoal = 4'h1 << sampLog;
    wire lastDone = sampling && adcDone && (sampCnt == sampGoal - 4'h1);
    assign adcStart = sampling && !adcBusy && !adcDone;
    wire delayZero = (delayCnt == 16'h0000);
    wire releaseEv = (state == S_CHECK) && delayZero && !touchNow && ctrlEnable;
    wire doneEv = (state == S_CHECK) && delayZero && touchNow && ctrlEnable;
    // Sense ignored until the pullup has settled and the sync has flushed
    wire touchEv = (state == S_DETECT) && delayZero && touchNow && ctrlEnable;

    // =====================================================
    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE: if (ctrlEnable) next_state = S_DETECT;
            S_DETECT: begin
                if (!ctrlEnable) next_state = S_IDLE;
                else if (touchNow && delayZero) next_state = S_DEBOUNCE;
            end
            S_DEBOUNCE: if (delayZero) next_state = touchNow ? S_XSETTLE : S_DETECT;
            S_XSETTLE: if (delayZero) next_state = S_XSAMPLE;
            S_XSAMPLE: if (lastDone) next_state = S_YSETTLE;
            S_YSETTLE: if (delayZero) next_state = S_YSAMPLE;
            S_YSAMPLE: if (lastDone) next_state = S_CHECK;
            S_CHECK: begin
                if (!ctrlEnable) next_state = S_IDLE;
                else if (delayZero) next_state = touchNow ? S_XSETTLE : S_DETECT;
            end
        endcase
    end

    always_comb begin
        next_delay = delayZero ? delayCnt : delayCnt - 16'h0001;
        if (next_state != state) begin
            if (next_state == S_DEBOUNCE) next_delay = debounceReg;
            else next_delay = settleReg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= S_IDLE;
            delayCnt <= 16'h0000;
            adcBusy <= 1'b0;
            sampCnt <= 4'h0;
        end else begin
            state <= next_state;
            delayCnt <= next_delay;
            adcBusy <= adcStart || (adcBusy && !adcDone);
            sampCnt <= (!sampling || lastDone) ? 4'h0 : sampCnt + 4'(adcDone);
        end
    end

    // Accumulators restart with every measurement set
    always_ff @(posedge clk_sys) begin
        if (rst || (state != S_XSETTLE && next_state == S_XSETTLE)) begin
            xAcc <= '0;
            yAcc <= '0;
        end else if (adcDone && state == S_XSAMPLE) begin
            xAcc <= xAcc + ACC_W'(adcData);
        end else if (adcDone && state == S_YSAMPLE) begin
            yAcc <= yAcc + ACC_W'(adcData);
        end
    end

    // A set is published only once the touch is reconfirmed
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            xPos <= '0;
            yPos <= '0;
        end else if (doneEv) begin
            xPos <= ADC_W'(xAcc >> sampLog);
            yPos <= ADC_W'(yAcc >> sampLog);
        end
    end

    // =====================================================
    // Register bus
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFF_LIVE);
    endfunction

    function automatic logic [31:0] regValue(input logic [7:0] a);
        unique case (a)
            OFF_CTRL: return {31'h0, ctrlEnable};
            OFF_DEBOUNCE: return {16'h0, debounceReg};
            OFF_SETTLE: return {16'h0, settleReg};
            OFF_SAMPLES: return {30'h0, sampLog};
            OFF_STATUS: return {29'h0, status};
            OFF_MASK: return {29'h0, maskReg};
            OFF_XPOS: return {22'h0, xPos};
            OFF_YPOS: return {22'h0, yPos};
            OFF_LIVE: return {23'h0, touchNow, state};
            default: return 32'h0;
        endcase
    endfunction

    wire [31:0] strbMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
    // Function reads registers directly, so it must sit where those are sensed
    logic [31:0] wrOld;
    always_comb wrOld = regValue(awAddrQ);
    wire [31:0] wrVal = (wrOld & ~strbMask) | (wDataQ & strbMask);
    wire wrCtrl = doWrite && awAddrQ == OFF_CTRL;
    wire wrDeb = doWrite && awAddrQ == OFF_DEBOUNCE;
    wire wrSet = doWrite && awAddrQ == OFF_SETTLE;
    wire wrSamp = doWrite && awAddrQ == OFF_SAMPLES;
    wire wrMask = doWrite && awAddrQ == OFF_MASK;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ <= 32'h0;
            wStrbQ <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrlEnable <= 1'b0;
            debounceReg <= RST_DEBOUNCE;
            settleReg <= RST_SETTLE;
            sampLog <= RST_SAMP_LOG;
            maskReg <= '0;
        end else begin
            if (wrCtrl) ctrlEnable <= wrVal[0];
            if (wrDeb) debounceReg <= wrVal[15:0];
            if (wrSet) settleReg <= wrVal[15:0];
            if (wrSamp) sampLog <= wrVal[1:0];
            if (wrMask) maskReg <= wrVal[ST_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (arTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= regValue(s_axi_araddr);
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // =====================================================
    // Interrupt status: read clears, release clears touch, set wins
    wire stsRead = arTake && s_axi_araddr == OFF_STATUS;
    wire [ST_W-1:0] stsSet = {releaseEv, doneEv, touchEv};
    wire [ST_W-1:0] stsClr = {ST_W{stsRead}} | {{(ST_W-1){1'b0}}, releaseEv};

    always_ff @(posedge clk_sys) begin
        if (rst) status <= '0;
        else status <= (status & ~stsClr) | stsSet;
    end
    assign irq = |(status & maskReg);

    // =====================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_detect_pins;
        state == S_DETECT |-> xHighPullEn && !xHighOe && yLowOe && !xLowOe && !yHighOe;
    endproperty
    a_detect_pins: assert property (p_detect_pins) else $error("detect drive wrong");

    property p_touch_flag;
        touchEv |=> status[ST_TOUCH] && state == S_DEBOUNCE;
    endproperty
    a_touch_flag: assert property (p_touch_flag) else $error("touch not flagged");

    property p_xread_pins;
        state == S_XSAMPLE |-> xHighOe && xHighOut && xLowOe && !yLowOe && !adcSelXHigh;
    endproperty
    a_xread_pins: assert property (p_xread_pins) else $error("x read drive wrong");

    property p_yread_pins;
        state == S_YSAMPLE |-> yHighOe && yHighOut && yLowOe && !xLowOe && adcSelXHigh;
    endproperty
    a_yread_pins: assert property (p_yread_pins) else $error("y read drive wrong");

    property p_low_lines;
        !(xLowOe && yLowOe) && !(xHighOe && yHighOe);
    endproperty
    a_low_lines: assert property (p_low_lines) else $error("panel lines fight");

    sequence s_xsample_end;
        state == S_XSAMPLE ##1 state != S_XSAMPLE;
    endsequence
    property p_auto_seq;
        s_xsample_end |-> state == S_YSETTLE;
    endproperty
    a_auto_seq: assert property (p_auto_seq) else $error("x read not followed by y");

    property p_count_done;
        lastDone |-> $past(sampCnt) == sampGoal - 4'h1 || sampGoal == 4'h1;
    endproperty
    a_count_done: assert property (p_count_done) else $error("conversion count wrong");

    property p_adc_only_reading;
        adcStart |-> sampling && !adcBusy;
    endproperty
    a_adc_only_reading: assert property (p_adc_only_reading) else $error("stray conversion");

    property p_release_clear;
        releaseEv |=> !status[ST_TOUCH] && status[ST_DISCARD] && state == S_DETECT;
    endproperty
    a_release_clear: assert property (p_release_clear) else $error("release not handled");

    property p_settle_hold;
        state == S_XSETTLE && !delayZero |=> state == S_XSETTLE;
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("settle cut short");

    property p_average;
        doneEv |=> xPos == ADC_W'($past(xAcc) >> sampLog) && status[ST_DONE];
    endproperty
    a_average: assert property (p_average) else $error("average not published");
endmodule // fwtr_readout

// ===== bench/fwtr_panel_model.sv
// Behavioural four-wire panel and 10-bit ADC facing the touch readout.
// Assumes the readout's pad controls and an ADC clocked by clk_sys.
module fwtr_panel_model import fwtr_pkg::*; (
    input wire logic clk_sys,
    input wire logic touched,
    input wire logic [ADC_W-1:0] xPos,
    input wire logic [ADC_W-1:0] yPos,
    input wire logic xHighOut,
    input wire logic xHighOe,
    input wire logic xHighPullEn,
    input wire logic yLowOut,
    input wire logic yLowOe,
    input wire logic adcStart,
    input wire logic adcSelXHigh,
    output logic xHighIn,
    output logic adcDone = 1'b0,
    output logic [ADC_W-1:0] adcData = 10'h155
);
    timeunit 1ns;
    timeprecision 1ns;
    logic flip = 1'b0;
    logic sel = 1'b0;
    logic [2:0] waitCnt = 3'h0;
    logic [1:0] latSel = 2'h0;
    // =====================================================
    // Pad: an undriven, unpulled x-high line wanders each cycle
    assign xHighIn = xHighOe ? xHighOut
                   : (touched && yLowOe && !yLowOut) ? 1'b0
                   : xHighPullEn ? 1'b1 : flip;
    // =====================================================
    // Converter: latency rotates 1..4 cycles, data only valid with done
    always @(posedge clk_sys) begin
        flip <= ~flip;
        adcDone <= 1'b0;
        adcData <= ~adcData;
        if (adcStart) begin
            waitCnt <= 3'(latSel) + 3'h1;
            latSel <= latSel + 2'h1;
            sel <= adcSelXHigh;
        end else if (waitCnt == 3'h1) begin
            adcDone <= 1'b1;
            adcData <= sel ? yPos : xPos;
            waitCnt <= 3'h0;
        end else if (waitCnt != 3'h0) begin
            waitCnt <= waitCnt - 3'h1;
        end
    end
endmodule // fwtr_panel_model

// ===== bench/fwtr_testbench.sv
// Self-checking bench: AXI4-Lite master with queued expectations.
// Assumes fwtr_panel_model as the panel and ADC, clock at 25 MHz.
module testbench import fwtr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} fwtr_exp_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, touched = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic xHighIn, xHighOut, xHighOe, xHighPullEn, yHighOut, yHighOe;
    logic xLowOut, xLowOe, yLowOut, yLowOe, adcStart, adcSelXHigh, adcDone, irq;
    logic [ADC_W-1:0] adcData, xPos = 10'h000, yPos = 10'h000;
    int errorCnt = 0, nCompared = 0, cycles = 0, starts = 0, seed = 74098;
    logic [1:0] bq[$];
    fwtr_exp_t rq[$];

    fwtr_readout dut(.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xHighIn, .xHighOut,
        .xHighOe, .xHighPullEn, .yHighOut, .yHighOe, .xLowOut, .xLowOe, .yLowOut,
        .yLowOe, .adcStart, .adcSelXHigh, .adcDone, .adcData, .irq);
    fwtr_panel_model panel(.clk_sys, .touched, .xPos, .yPos, .xHighOut, .xHighOe,
        .xHighPullEn, .yLowOut, .yLowOe, .adcStart, .adcSelXHigh, .xHighIn,
        .adcDone, .adcData);

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // =====================================================
    // Shared helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        nCompared++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic endSim();
        $display("comparisons %0d, mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Leading edge keeps a release and the next raise in different steps
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                            input logic [1:0] r);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        @(posedge clk_sys);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge clk_sys);
            if (s_axi_bvalid) begin
                b = 1'b1;
                s_axi_bready <= 1'b0;
            end
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask
    task automatic axiRead(input logic [7:0] a, input logic [31:0] d,
                           input logic [31:0] m, input logic [1:0] r);
        logic ar, got;
        ar = 1'b1;
        got = 1'b0;
        @(posedge clk_sys);
        rq.push_back('{d, m, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got) begin
            @(posedge clk_sys);
            if (s_axi_rvalid) begin
                got = 1'b1;
                s_axi_rready <= 1'b0;
            end
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask
    // =====================================================
    // Monitor, pad checks at each conversion and the run limit
    always @(posedge clk_sys) begin
        fwtr_exp_t e;
        cycles++;
        if (adcStart)
            starts++;
        if (s_axi_bvalid && s_axi_bready)
            check(32'(s_axi_bresp), 32'(bq.pop_front()), "write response");
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            check(s_axi_rdata & e.m, e.d, "read data");
            check(32'(s_axi_rresp), 32'(e.r), "read response");
        end
        if (adcStart && !adcSelXHigh)
            check(32'({xHighOe, xHighOut, xLowOe, xLowOut, yLowOe, yHighOe, xHighPullEn}),
                  32'h70, "x read pads");
        if (adcStart && adcSelXHigh)
            check(32'({yHighOe, yHighOut, yLowOe, yLowOut, xLowOe, xHighOe, xHighPullEn}),
                  32'h70, "y read pads");
        if (cycles == 20000) begin
            errorCnt++;
            endSim();
        end
    end
    // =====================================================
    // Main sequence
    initial begin
        int n, base;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        axiRead(OFF_DEBOUNCE, 32'(RST_DEBOUNCE), 32'hFFFFFFFF, RESP_OKAY);
        axiRead(OFF_SETTLE, 32'(RST_SETTLE), 32'hFFFFFFFF, RESP_OKAY);
        axiRead(OFF_SAMPLES, 32'(RST_SAMP_LOG), 32'hFFFFFFFF, RESP_OKAY);
        axiRead(OFF_MASK, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        axiRead(8'h24, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        axiRead(8'h02, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        axiWrite(8'h24, 32'h1, RESP_SLVERR);
        axiWrite(OFF_STATUS, 32'h7, RESP_OKAY);
        axiRead(OFF_STATUS, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        $display("test registers done");
        axiWrite(OFF_DEBOUNCE, 32'h4, RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        axiWrite(OFF_SETTLE, 32'h0000AB04, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axiRead(OFF_SETTLE, 32'({RST_SETTLE[15:8], 8'h04}), 32'hFFFFFFFF, RESP_OKAY);
        axiWrite(OFF_CTRL, 32'h1, RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        check(32'({xHighPullEn, yLowOe, yLowOut, xLowOe, yHighOe, xHighOe, irq}),
              32'h60, "detect pads");
        for (int code = 0; code < 4; code++) begin
            xPos <= 10'($random(seed));
            yPos <= 10'($random(seed));
            axiWrite(OFF_SAMPLES, 32'(code), RESP_OKAY);
            axiWrite(OFF_MASK, 32'h1, RESP_OKAY);
            axiRead(OFF_STATUS, 32'h0, 32'h0, RESP_OKAY);
            @(posedge clk_sys);
            touched <= 1'b1;
            base = starts;
            n = 0;
            while (!irq) begin
                @(posedge clk_sys);
                n++;
            end
            check(32'(n <= 6), 32'h1, "touch interrupt delay");
            axiWrite(OFF_MASK, 32'h2, RESP_OKAY);
            axiRead(OFF_STATUS, 32'h1, 32'h1, RESP_OKAY);
            while (!irq)
                @(posedge clk_sys);
            check(32'(starts - base), 32'(2 << code), "conversion count");
            axiRead(OFF_XPOS, 32'(xPos), 32'hFFFFFFFF, RESP_OKAY);
            axiRead(OFF_YPOS, 32'(yPos), 32'hFFFFFFFF, RESP_OKAY);
            axiRead(OFF_STATUS, 32'h2, 32'h2, RESP_OKAY);
            axiWrite(OFF_MASK, 32'h4, RESP_OKAY);
            touched <= 1'b0;
            while (!irq)
                @(posedge clk_sys);
            axiRead(OFF_STATUS, 32'h4, 32'h5, RESP_OKAY);
            @(posedge clk_sys);
            check(32'(irq), 32'h0, "interrupt after clear");
            $display("test samples code %0d done", code);
        end
        endSim();
    end
endmodule // testbench
